// >>> rtl/iptc_flag_bit.sv
/*
 one sticky flag bit: hardware set, software write, set wins.
 assumes set and write enables are synchronous to the clock.
*/
`timescale 1ns/1ns
module iptc_flag_bit (
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic set_i,
   input wire logic wr_i,
   input wire logic wdata_i,
   output logic flag_o
);
   logic flag_reg;
   // a request in the clear cycle must survive
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         flag_reg <= 1'b0;
      end else if (set_i) begin
         flag_reg <= 1'b1; // [RULE17]
      end else if (wr_i) begin
         flag_reg <= wdata_i;
      end
   end
   assign flag_o = flag_reg;
endmodule : iptc_flag_bit

// >>> rtl/iptc_pkg.sv
/*
 interrupt priority and trap control: register map, field positions, reset values.
 assumes a single 250 MHz clock and a plain one-cycle register port.
*/
// Operation
// [RULE1] cpu level low bits at status 7:5
// [RULE2] top level bit not settable by software
// [RULE3] effective level is top bit over low
// [RULE4] low 111 blocks all user interrupts
// [RULE5] nesting off freezes low level bits
// [RULE6] top bit reads one above seven
// [RULE7] overflow trap enables for accumulators a,b
// [RULE8] catastrophic overflow flags for a and b
// [RULE9] bad shift flag on shift error
// [RULE10] zero divide flag on divide trap
// [RULE11] stack fault flag on stack trap
// [RULE12] oscillator loss flag on failure trap
// [RULE13] edge select per external interrupt, 1 falling
// [RULE14] flag reads one after request occurred
// [RULE15] flag word zero bit layout fixed
// [RULE16] unimplemented bits ignore writes, read zero
// [RULE17] flags stay set until software clears
// [RULE18] alternate vector table select bit
// [RULE19] control one holds nesting and traps
// [RULE20] trap flags sticky until written zero
// [RULE21] nesting off blocks preemption of handler
package iptc_pkg;
   localparam logic [2:0] IPTC_ADDR_STATUS = 3'h0;
   localparam logic [2:0] IPTC_ADDR_CORE = 3'h1;
   localparam logic [2:0] IPTC_ADDR_CTL1 = 3'h2;
   localparam logic [2:0] IPTC_ADDR_CTL2 = 3'h3;
   localparam logic [2:0] IPTC_ADDR_FLAGS0 = 3'h4;
   localparam logic [2:0] IPTC_ADDR_ACTIVE = 3'h5;
   localparam int IPTC_LVL_LO = 5;
   localparam int IPTC_LVL_TOP = 3;
   localparam int IPTC_NEST = 15;
   localparam int IPTC_COVA = 12;
   localparam int IPTC_COVB = 11;
   localparam int IPTC_ACC_A_OVF_TRAP_EN = 10;
   localparam int IPTC_ACC_B_OVF_TRAP_EN = 9;
   localparam int IPTC_SHIFT = 7;
   localparam int IPTC_DIV0 = 6;
   localparam int IPTC_STK = 2;
   localparam int IPTC_OSC = 1;
   localparam int IPTC_ALT = 15;
   localparam logic [15:0] IPTC_CTL1_MASK = 16'h9ec6;
   localparam logic [15:0] IPTC_CTL2_MASK = 16'h8007;
   localparam logic [15:0] IPTC_FLAGS0_MASK = 16'h3fef;
   localparam logic [2:0] IPTC_LVL_RST = 3'h0;
   localparam logic [15:0] IPTC_REG_RST = 16'h0000;
   localparam logic [2:0] IPTC_LVL_FULL = 3'h7;
   localparam logic [3:0] IPTC_LVL_USER_MAX = 4'h7;
   localparam int IPTC_NSRC = 14;

   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } iptc_bus_t;

   typedef struct packed {
      logic cova;
      logic covb;
      logic shift;
      logic div0;
      logic stk;
      logic osc;
   } iptc_trap_t;
endpackage : iptc_pkg

// >>> rtl/iptc_top.sv
/*
 interrupt priority, trap flag and edge control registers with flag word zero.
 assumes the core reports trap causes, level pushes and handler entry/exit as one-cycle pulses.
*/
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module iptc_top (
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic [2:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire iptc_pkg::iptc_trap_t TRAP_CAUSE,
   input wire logic [13:0] SRC_REQ,
   input wire logic TRAP_ENTER,
   input wire logic TRAP_EXIT,
   input wire logic HANDLER_ENTER,
   input wire logic HANDLER_EXIT,
   input wire logic [2:0] HANDLER_LEVEL,
   output logic [3:0] CPU_LEVEL,
   output logic USER_BLOCKED,
   output logic PREEMPT_ALLOWED,
   output logic ACC_A_OVF_TRAP_EN,
   output logic ACC_B_OVF_TRAP_EN,
   output logic ALT_TABLE_SELECT,
   output logic [2:0] EXT_EDGE_SEL,
   output logic [13:0] FLAGS
);
   import iptc_pkg::*;

   iptc_bus_t bus;
   logic [2:0] cpu_level_low_reg;
   logic cpu_level_top_reg;
   logic [15:0] ctl1_reg;
   logic [15:0] ctl2_reg;
   logic [13:0] flag_vec;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic in_handler_reg;
   logic [3:0] cpu_level_reg;
   logic user_blocked_reg;
   logic preempt_reg;
   logic [2:0] edge_reg;
   logic [13:0] flags_out_reg;
   logic alt_reg;
   logic ova_reg;
   logic ovb_reg;
   logic [15:0] trap_set;
   logic wr_ctl1;
   logic nesting_off;

   typedef enum logic [1:0] {
      IPTC_IDLE = 2'b01,
      IPTC_BUSY = 2'b10
   } iptc_state_t;
   iptc_state_t state_reg;

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign nesting_off = ctl1_reg[IPTC_NEST];
   assign wr_ctl1 = bus.wr && (bus.addr == IPTC_ADDR_CTL1);

   // cpu level low bits: software write unless nesting off, core pushes on handler entry
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cpu_level_low_reg <= IPTC_LVL_RST;
      end else if (HANDLER_ENTER) begin
         cpu_level_low_reg <= HANDLER_LEVEL; // [RULE1]
      end else if (bus.wr && bus.addr == IPTC_ADDR_STATUS && !nesting_off) begin // [RULE5]
         cpu_level_low_reg <= bus.wdata[IPTC_LVL_LO +: 3]; // [RULE1]
      end
   end

   // top level bit only moves with trap entry/exit, never from software
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cpu_level_top_reg <= 1'b0;
      end else if (TRAP_ENTER) begin
         cpu_level_top_reg <= 1'b1; // [RULE2]
      end else if (TRAP_EXIT) begin
         cpu_level_top_reg <= 1'b0; // [RULE2]
      end
   end

   // trap flags sticky; writes of one to a trap flag are allowed but set still wins
   always_comb begin
      trap_set = 16'h0000;
      trap_set[IPTC_COVA] = TRAP_CAUSE.cova; // [RULE8]
      trap_set[IPTC_COVB] = TRAP_CAUSE.covb; // [RULE8]
      trap_set[IPTC_SHIFT] = TRAP_CAUSE.shift; // [RULE9]
      trap_set[IPTC_DIV0] = TRAP_CAUSE.div0; // [RULE10]
      trap_set[IPTC_STK] = TRAP_CAUSE.stk; // [RULE11]
      trap_set[IPTC_OSC] = TRAP_CAUSE.osc; // [RULE12]
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctl1_reg <= IPTC_REG_RST;
      end else if (wr_ctl1) begin
         ctl1_reg <= ((bus.wdata & IPTC_CTL1_MASK) | trap_set); // [RULE19] [RULE16] [RULE20]
      end else begin
         ctl1_reg <= ctl1_reg | trap_set; // [RULE20]
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctl2_reg <= IPTC_REG_RST;
      end else if (bus.wr && bus.addr == IPTC_ADDR_CTL2) begin
         ctl2_reg <= bus.wdata & IPTC_CTL2_MASK; // [RULE13] [RULE18] [RULE16]
      end
   end

   // flag word zero; bit 4 has no source and stays zero
   genvar g;
   generate
      for (g = 0; g < IPTC_NSRC; g = g + 1) begin : g_flag
         if (IPTC_FLAGS0_MASK[g]) begin : g_impl
            iptc_flag_bit u_flag (
               .SYS_CLK(SYS_CLK),
               .RESETN(RESETN),
               .set_i(SRC_REQ[g]),
               .wr_i(bus.wr && bus.addr == IPTC_ADDR_FLAGS0),
               .wdata_i(bus.wdata[g]),
               .flag_o(flag_vec[g])
            ); // [RULE14] [RULE15] [RULE17]
         end else begin : g_none
            assign flag_vec[g] = 1'b0; // [RULE16]
         end
      end
   endgenerate

   // handler tracking for nesting control
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= IPTC_IDLE;
      end else begin
         case (state_reg)
            IPTC_IDLE: begin
               if (HANDLER_ENTER) begin
                  state_reg <= IPTC_BUSY;
               end
            end
            IPTC_BUSY: begin
               if (HANDLER_EXIT) begin
                  state_reg <= IPTC_IDLE;
               end
            end
            default: begin
               state_reg <= IPTC_IDLE;
            end
         endcase
      end
   end
   assign in_handler_reg = (state_reg == IPTC_BUSY);

   // registered status outputs
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cpu_level_reg <= 4'h0;
         user_blocked_reg <= 1'b0;
         preempt_reg <= 1'b1;
      end else begin
         cpu_level_reg <= {cpu_level_top_reg, cpu_level_low_reg}; // [RULE3]
         user_blocked_reg <= cpu_level_top_reg || (cpu_level_low_reg == IPTC_LVL_FULL); // [RULE3] [RULE4]
         preempt_reg <= !(nesting_off && in_handler_reg); // [RULE21]
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ova_reg <= 1'b0;
         ovb_reg <= 1'b0;
         alt_reg <= 1'b0;
         edge_reg <= 3'h0;
         flags_out_reg <= 14'h0000;
      end else begin
         ova_reg <= ctl1_reg[IPTC_ACC_A_OVF_TRAP_EN]; // [RULE7]
         ovb_reg <= ctl1_reg[IPTC_ACC_B_OVF_TRAP_EN]; // [RULE7]
         alt_reg <= ctl2_reg[IPTC_ALT]; // [RULE18]
         edge_reg <= ctl2_reg[2:0]; // [RULE13]
         flags_out_reg <= flag_vec;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rdata_next = 16'h0000;
      case (bus.addr)
         IPTC_ADDR_STATUS: rdata_next[IPTC_LVL_LO +: 3] = cpu_level_low_reg;
         IPTC_ADDR_CORE: rdata_next[IPTC_LVL_TOP] = ({cpu_level_top_reg, cpu_level_low_reg} > IPTC_LVL_USER_MAX); // [RULE6]
         IPTC_ADDR_CTL1: rdata_next = ctl1_reg & IPTC_CTL1_MASK; // [RULE16]
         IPTC_ADDR_CTL2: rdata_next = ctl2_reg & IPTC_CTL2_MASK;
         IPTC_ADDR_FLAGS0: rdata_next = {2'b00, flag_vec}; // [RULE14]
         IPTC_ADDR_ACTIVE: rdata_next[0] = in_handler_reg;
         default: rdata_next = 16'h0000;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_reg <= 16'h0000;
      end else if (bus.rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign RDATA = rdata_reg;
   assign CPU_LEVEL = cpu_level_reg;
   assign USER_BLOCKED = user_blocked_reg;
   assign PREEMPT_ALLOWED = preempt_reg;
   assign ACC_A_OVF_TRAP_EN = ova_reg;
   assign ACC_B_OVF_TRAP_EN = ovb_reg;
   assign ALT_TABLE_SELECT = alt_reg;
   assign EXT_EDGE_SEL = edge_reg;
   assign FLAGS = flags_out_reg;
endmodule : iptc_top

// >>> tb/iptc_core_model.sv
/*
 stand-in for the core and the requesting peripherals.
 assumes one caller thread; each call is one clock of pulses.
*/
`timescale 1ns/1ns
module iptc_core_model (
   input wire logic sys_clk,
   output iptc_pkg::iptc_trap_t trap_cause,
   output logic [13:0] src_req,
   output logic trap_enter,
   output logic trap_exit,
   output logic h_enter,
   output logic h_exit,
   output logic [2:0] h_level
);
   import iptc_pkg::*;
   initial begin
      {trap_cause, src_req, trap_enter, trap_exit, h_enter, h_exit, h_level} = '0;
   end
   // level is inverted on release so a stale value can never pass for a good one
   task automatic pulse(input logic [26:0] v);
      @(posedge sys_clk);
      {trap_cause, src_req, trap_enter, trap_exit, h_enter, h_exit, h_level} <= v;
      @(posedge sys_clk);
      {trap_cause, src_req, trap_enter, trap_exit, h_enter, h_exit, h_level} <= {24'h0, ~v[2:0]};
   endtask : pulse
endmodule : iptc_core_model

// >>> tb/iptc_top_asserts.sv
/*
 port-level assertions for iptc_top.
 assumes registered read data and a one-cycle lag from register state to outputs.
*/
`timescale 1ns/1ns
module iptc_top_asserts (
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic [2:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic [13:0] SRC_REQ,
   input wire logic TRAP_ENTER,
   input wire logic TRAP_EXIT,
   input wire logic [3:0] CPU_LEVEL,
   input wire logic USER_BLOCKED,
   input wire logic ACC_A_OVF_TRAP_EN,
   input wire logic ACC_B_OVF_TRAP_EN,
   input wire logic ALT_TABLE_SELECT,
   input wire logic [2:0] EXT_EDGE_SEL,
   input wire logic [13:0] FLAGS
);
   import iptc_pkg::*;
   localparam logic [15:0] MSK [8] = '{16'h00e0, 16'h0008, IPTC_CTL1_MASK, IPTC_CTL2_MASK, IPTC_FLAGS0_MASK,
      16'h0001, 16'h0000, 16'h0000};
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   sequence wr_at(logic [2:0] a);
      WR && ADDR == a;
   endsequence
   sequence trap_in;
      TRAP_ENTER ##1 !TRAP_EXIT;
   endsequence
   rd_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000) else $error("read data not idle");
   rsv_bits_a: assert property ($past(RD) |-> (RDATA & ~MSK[$past(ADDR)]) == 16'h0000)
      else $error("unimplemented bit read as one");
   blocked_a: assert property (USER_BLOCKED == (CPU_LEVEL[3] || CPU_LEVEL[2:0] == IPTC_LVL_FULL))
      else $error("user block disagrees with level");
   top_bit_a: assert property (trap_in |-> ##1 CPU_LEVEL[3] && USER_BLOCKED)
      else $error("trap entry did not raise level");
   flag_set_a: assert property (|(SRC_REQ & 14'h3fef) |-> ##2
      (FLAGS & $past(SRC_REQ, 2) & 14'h3fef) == ($past(SRC_REQ, 2) & 14'h3fef)) else $error("flag not set");
   flag_keep_a: assert property (|($past(FLAGS) & ~FLAGS) |-> $past(WR, 2) && $past(ADDR, 2) == IPTC_ADDR_FLAGS0)
      else $error("flag cleared without write");
   edge_sel_a: assert property (wr_at(IPTC_ADDR_CTL2) |-> ##2 EXT_EDGE_SEL == $past(WDATA[2:0], 2) &&
      ALT_TABLE_SELECT == $past(WDATA[IPTC_ALT], 2)) else $error("edge or table select wrong");
   trap_en_a: assert property (wr_at(IPTC_ADDR_CTL1) |-> ##2
      {ACC_A_OVF_TRAP_EN, ACC_B_OVF_TRAP_EN} == $past(WDATA[10:9], 2)) else $error("trap enable wrong");
endmodule : iptc_top_asserts
bind iptc_top iptc_top_asserts iptc_top_asserts_i (.SYS_CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .SRC_REQ,
   .TRAP_ENTER, .TRAP_EXIT, .CPU_LEVEL, .USER_BLOCKED, .ACC_A_OVF_TRAP_EN, .ACC_B_OVF_TRAP_EN,
   .ALT_TABLE_SELECT, .EXT_EDGE_SEL, .FLAGS);

// >>> tb/test_interrupt_priority_trap_control.sv
/*
 self-checking bench for iptc_top with a core stand-in.
 assumes the register port and pulse inputs described for iptc_top.
*/
`timescale 1ns/1ns
module test_interrupt_priority_trap_control;
   import iptc_pkg::*;
   localparam logic [15:0] WM [8] = '{16'h00e0, 16'h0000, IPTC_CTL1_MASK, IPTC_CTL2_MASK, IPTC_FLAGS0_MASK,
      16'h0000, 16'h0000, 16'h0000};
   localparam int TP [6] = '{IPTC_OSC, IPTC_STK, IPTC_DIV0, IPTC_SHIFT, IPTC_COVB, IPTC_COVA};
   logic sys_clk = 0, resetn = 0, wr = 0, rd = 0, trap_enter, trap_exit, h_enter, h_exit, blk, pre, ena, enb, alt;
   logic [2:0] addr = 0, h_level, edge_sel;
   logic [15:0] wdata = 0, rdata, v, e;
   logic [15:0] ex [8] = '{default: 16'h0000};
   logic [13:0] src_req, flags;
   logic [3:0] lvl;
   iptc_trap_t trap_cause;
   int n_errors = 0, checked = 0, seed = 85;
   iptc_core_model iptc_core_model_i (.sys_clk, .trap_cause, .src_req, .trap_enter, .trap_exit, .h_enter, .h_exit,
      .h_level);
   iptc_top iptc_top_i (.SYS_CLK(sys_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .TRAP_CAUSE(trap_cause), .SRC_REQ(src_req), .TRAP_ENTER(trap_enter), .TRAP_EXIT(trap_exit),
      .HANDLER_ENTER(h_enter), .HANDLER_EXIT(h_exit), .HANDLER_LEVEL(h_level), .CPU_LEVEL(lvl), .USER_BLOCKED(blk),
      .PREEMPT_ALLOWED(pre), .ACC_A_OVF_TRAP_EN(ena), .ACC_B_OVF_TRAP_EN(enb), .ALT_TABLE_SELECT(alt),
      .EXT_EDGE_SEL(edge_sel), .FLAGS(flags));
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rchk
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   initial begin
      // about twenty times the expected run
      #60000;
      n_errors++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         rchk(3'(a), 16'h0000);
      end
      for (int i = 0; i < 20; i++) begin
         v = (i < 2) ? {16{i[0]}} : 16'($random(seed));
         for (int a = 0; a < 7; a++) begin
            if (a != 5 && !(a == 0 && ex[2][IPTC_NEST])) begin
               ex[a] = v & WM[a];
            end
            if (a != 5) begin
               wreg(3'(a), v);
            end
         end
         for (int a = 0; a < 8; a++) begin
            rchk(3'(a), ex[a]);
         end
         chk({13'h0, edge_sel}, {13'h0, ex[3][2:0]});
         chk({alt, ena, enb, blk, 8'h0, lvl}, {ex[3][15], ex[2][10:9], ex[0][7:5] == 3'h7, 9'h0, ex[0][7:5]});
         chk({2'h0, flags}, ex[4]);
      end
      wreg(IPTC_ADDR_CTL1, 16'h0000);
      wreg(IPTC_ADDR_FLAGS0, 16'h0000);
      e = 16'h0000;
      for (int k = 0; k < 6; k++) begin
         iptc_core_model_i.pulse(27'h200000 << k);
         e[TP[k]] = 1'b1;
         rchk(IPTC_ADDR_CTL1, e);
      end
      wreg(IPTC_ADDR_CTL1, 16'h0000);
      rchk(IPTC_ADDR_CTL1, 16'h0000);
      e = 16'h0000;
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 16'hffff : 16'($random(seed));
         iptc_core_model_i.pulse({6'h00, v[13:0], 7'h00});
         e = e | (v & IPTC_FLAGS0_MASK);
         @(posedge sys_clk);
         #1;
         chk({2'h0, flags}, e);
      end
      rchk(IPTC_ADDR_FLAGS0, e);
      wreg(IPTC_ADDR_STATUS, 16'h0060);
      iptc_core_model_i.pulse(27'h40);
      @(posedge sys_clk);
      #1;
      chk({11'h0, blk, lvl}, 16'h001b);
      wreg(IPTC_ADDR_CORE, 16'h0000);
      rchk(IPTC_ADDR_CORE, 16'h0008);
      iptc_core_model_i.pulse(27'h20);
      rchk(IPTC_ADDR_CORE, 16'h0000);
      chk({11'h0, blk, lvl}, 16'h0003);
      wreg(IPTC_ADDR_CTL1, 16'h8000);
      iptc_core_model_i.pulse(27'h15);
      wreg(IPTC_ADDR_STATUS, 16'h00e0);
      rchk(IPTC_ADDR_STATUS, 16'h00a0);
      rchk(IPTC_ADDR_ACTIVE, 16'h0001);
      chk({15'h0, pre}, 16'h0000);
      iptc_core_model_i.pulse(27'h08);
      @(posedge sys_clk);
      #1;
      chk({15'h0, pre}, 16'h0001);
      close_out();
   end
endmodule : test_interrupt_priority_trap_control
